// file: core/fault_status_pkg.sv
// Command codes, bit positions and reset values of the status bank
package fault_status_pkg;

  // Command codes of the two registers
  localparam logic [7:0]  CMD_SUMMARY_WORD     = 8'h79;
  localparam logic [7:0]  CMD_OUTPUT_VOLTAGE_SUMMARY_STATUS      = 8'h7A;

  // Fault summary word fields
  localparam int          SW_OUTPUT_VOLTAGE_SUMMARY_BIT          = 15;
  localparam int          SW_OUTPUT_CURRENT_SUMMARY_BIT          = 14;
  localparam int          SW_INPUT_BIT         = 13;
  localparam int          SW_MAKER_BIT         = 12;
  localparam int          SW_POWER_GOOD_LIVE_BIT         = 11;
  localparam int          SW_OTHER_BIT         = 9;
  localparam int          SB_BUSY_BIT          = 7;
  localparam int          SB_OFF_BIT           = 6;
  localparam int          SB_OUTPUT_VOLTAGE_SUMMARY_OV_BIT       = 5;

  // Write-word bits that request a clear
  localparam int          WR_BUSY_CLR_BIT      = 7;
  localparam int          WR_UNKNOWN_CLR_BIT   = 8;

  // Output voltage status fields
  localparam int          VS_OVF_BIT           = 7;
  localparam int          VS_OVW_BIT           = 6;
  localparam int          VS_UVW_BIT           = 5;
  localparam int          VS_UVF_BIT           = 4;
  localparam int          VS_LIMIT_BIT         = 3;
  localparam int          VS_TON_BIT           = 2;
  localparam int          VS_LATCH_LO          = 2;
  localparam int          VS_LATCH_HI          = 6;
  localparam int          VS_LATCH_W           = 5;

  // Overvoltage sources: fixed, tracking, pre-biased
  localparam int          OVP_SRC_W            = 3;

  // Reset values
  localparam logic [15:0] SUMMARY_WORD_RST     = 16'h0000;
  localparam logic [7:0]  OUTPUT_VOLTAGE_SUMMARY_STATUS_RST      = 8'h00;
  localparam logic [15:0] RD_DATA_RST          = 16'h0000;

  // Summary bits that may raise the alert (live bits 11 and 6 never do)
  localparam logic [15:0] ALERT_CAPABLE        = 16'hF2BF;

endpackage

// file: core/sticky_flags.sv
// Bank of latched flags: set by events, cleared by write-one or clear-all
`timescale 1ns/1ps
module sticky_flags
#(
  parameter int WIDTH = 8
)
(
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] set_evt,
  input  wire logic [WIDTH-1:0] clr_bits,
  input  wire logic             clr_all,
  output logic      [WIDTH-1:0] flags_ff
);

  logic [WIDTH-1:0] nxt_flags;

  // Set wins over a clear in the same cycle so no event is lost
  assign nxt_flags = (flags_ff & ~(clr_bits | {WIDTH{clr_all}})) | set_evt;

  // Flags start cleared
  always_ff @(posedge clock)
  begin
    if (srst)
      flags_ff <= '0;
    else
      flags_ff <= nxt_flags;
  end

endmodule

// file: core/fault_status_summary_regs.sv
// Fault summary word and output voltage status registers with alert summary
`timescale 1ns/1ps
module fault_status_summary_regs
  import fault_status_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        srst,
  // Decoded command port
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_code,
  input  wire logic        cmd_write,
  input  wire logic        cmd_is_word,
  input  wire logic [15:0] cmd_wdata,
  input  wire logic        clear_faults,
  // Output voltage events, one-cycle pulses or levels
  input  wire logic        ovp_fixed_evt,
  input  wire logic        ovp_tracking_evt,
  input  wire logic        ovp_prebias_evt,
  input  wire logic        out_overvoltage_warn,
  input  wire logic        out_undervoltage_warn,
  input  wire logic        out_undervoltage_fault,
  input  wire logic        out_setpoint_limit_hit,
  input  wire logic        turn_on_timeout,
  input  wire logic        busy_evt,
  // Summaries of the other status registers
  input  wire logic        unit_off_live,
  input  wire logic        output_current_summary_oc_summary,
  input  wire logic        vin_uv_summary,
  input  wire logic        temp_summary,
  input  wire logic        cml_summary,
  input  wire logic        none_above_summary,
  input  wire logic        output_current_summary,
  input  wire logic        input_fault_summary,
  input  wire logic        maker_fault_summary,
  input  wire logic        power_good_live,
  input  wire logic        other_fault_summary,
  // Alert masks, held in the mask registers outside
  input  wire logic [15:0] alert_mask_reg,
  input  wire logic [7:0]  alert_mask_output_voltage_summary,
  input  wire logic [2:0]  alert_mask_ext_reg,
  // Answers
  output logic             rd_valid_ff,
  output logic      [15:0] rd_data_ff,
  output logic             cmd_reject_ff,
  output logic             clear_unknown_cmd_ff,
  output logic      [15:0] summary_word_ff,
  output logic      [7:0]  output_voltage_status_ff,
  output logic             alert_ff
);

  // Command decoding shared by reads and writes
  function automatic logic hits(input logic [7:0] code,
                                input logic       word,
                                input logic [7:0] want,
                                input logic       want_word);
    hits = (code == want) && (word == want_word);
  endfunction

  // Write-one mask of the voltage status; unsupported low bits never clear
  function automatic logic [7:0] w1c_mask(input logic       wr,
                                          input logic [7:0] data);
    w1c_mask = wr ? {data[VS_OVF_BIT:VS_TON_BIT], 2'b00} : 8'h00;
  endfunction

  logic                 hit_word;
  logic                 hit_output_voltage_summary;
  logic                 wr_word;
  logic                 wr_output_voltage_summary;
  logic                 rd_word;
  logic                 rd_output_voltage_summary;
  logic                 bad_cmd;

  // A hit needs the right code and the right size of transaction
  assign hit_word = cmd_valid &&
                    hits(cmd_code, cmd_is_word, CMD_SUMMARY_WORD, 1'b1);
  assign hit_output_voltage_summary = cmd_valid &&
                    hits(cmd_code, cmd_is_word, CMD_OUTPUT_VOLTAGE_SUMMARY_STATUS, 1'b0);
  // Reads and writes split from the same hit
  assign wr_word  = hit_word && cmd_write;
  assign wr_output_voltage_summary  = hit_output_voltage_summary && cmd_write;
  assign rd_word  = hit_word && !cmd_write;
  assign rd_output_voltage_summary  = hit_output_voltage_summary && !cmd_write;
  // Wrong code or wrong transaction size is refused with no effect
  // A refused read returns neither data nor a read strobe
  assign bad_cmd  = cmd_valid && !hit_word && !hit_output_voltage_summary;

  // Write-one clear bits of the voltage status byte; bits 1 and 0 are not
  // stored, so a one written there is dropped rather than passed on
  logic [7:0]           output_voltage_summary_clr;

  assign output_voltage_summary_clr = w1c_mask(wr_output_voltage_summary, cmd_wdata[7:0]);

  // Overvoltage sources latched apart so the extended mask can split them
  logic [OVP_SRC_W-1:0] ovp_src_flags;
  logic [OVP_SRC_W-1:0] ovp_src_set;
  logic [OVP_SRC_W-1:0] ovp_src_clr;

  assign ovp_src_set = {ovp_prebias_evt, ovp_tracking_evt, ovp_fixed_evt};
  // Writing one at bit 7 clears every source together
  assign ovp_src_clr = {OVP_SRC_W{output_voltage_summary_clr[VS_OVF_BIT]}};

  // Clear-faults reaches every source latch; a new event still wins
  sticky_flags
  #(
    .WIDTH    (OVP_SRC_W)
  )
  u_ovp_flags
  (
    .clock    (clock),
    .srst     (srst),
    .set_evt  (ovp_src_set),
    .clr_bits (ovp_src_clr),
    .clr_all  (clear_faults),
    .flags_ff (ovp_src_flags)
  );

  // Remaining latched voltage flags, bits 6 down to 2
  // Each bit has its own set and clear, so one event never hides another
  logic [VS_LATCH_W-1:0] output_voltage_summary_lat_flags;
  logic [VS_LATCH_W-1:0] output_voltage_summary_lat_set;
  logic [VS_LATCH_W-1:0] output_voltage_summary_lat_clr;

  assign output_voltage_summary_lat_set = {out_overvoltage_warn,
                         out_undervoltage_warn,
                         out_undervoltage_fault,
                         out_setpoint_limit_hit,
                         turn_on_timeout};
  // Only the supported positions take a write of one; zeros leave bits alone
  assign output_voltage_summary_lat_clr = output_voltage_summary_clr[VS_LATCH_HI:VS_LATCH_LO];

  // Same latch bank, five bits wide, cleared by the same two paths
  sticky_flags
  #(
    .WIDTH    (VS_LATCH_W)
  )
  u_output_voltage_summary_flags
  (
    .clock    (clock),
    .srst     (srst),
    .set_evt  (output_voltage_summary_lat_set),
    .clr_bits (output_voltage_summary_lat_clr),
    .clr_all  (clear_faults),
    .flags_ff (output_voltage_summary_lat_flags)
  );

  // Busy flag: set by the busy event, cleared by a word write with bit 7.
  // Any word write with bit 7 set clears it, so 0080h and 0180h both do;
  // bit 8 requests the unknown-command clear; the other written bits are read-only and dropped.
  logic                 busy_ff;
  logic                 nxt_busy;
  logic                 busy_clr;
  logic                 busy_hold;

  assign busy_clr  = wr_word && cmd_wdata[WR_BUSY_CLR_BIT];
  // Clear-faults also drops the busy report
  assign busy_hold = busy_ff && !busy_clr && !clear_faults;
  // Set beats clear, so a busy event in the clearing cycle is not lost
  assign nxt_busy  = busy_hold || busy_evt;

  always_ff @(posedge clock)
  begin
    if (srst)
      busy_ff <= 1'b0;
    else
      busy_ff <= nxt_busy;
  end

  // Assembled output voltage status, bits 1 and 0 fixed at zero
  // Bit 7 reads as one flag although three source latches sit behind it
  logic                 ovf_flag;
  logic [7:0]           output_voltage_summary_status;

  assign ovf_flag    = |ovp_src_flags;
  assign output_voltage_summary_status = {ovf_flag, output_voltage_summary_lat_flags, 2'b00};

  // Summary byte follows the detail flags and the live inputs. Only bit 7
  // is stored here; bit 5 is the overvoltage flag seen through its latch,
  // so clearing that flag drops the summary bit in the same edge.
  logic [7:0]           summary_byte;

  assign summary_byte = {busy_ff,
                         unit_off_live,
                         ovf_flag,
                         output_current_summary_oc_summary,
                         vin_uv_summary,
                         temp_summary,
                         cml_summary,
                         none_above_summary};

  // Upper byte: category bits are plain ORs, never stored on their own.
  // The other categories arrive already summarised from their registers;
  // the power-good bit is live and has no latch at all.
  logic                 output_voltage_summary_any;
  logic [15:0]          summary_word;

  assign output_voltage_summary_any     = |output_voltage_summary_status;
  assign summary_word = {output_voltage_summary_any,
                         output_current_summary,
                         input_fault_summary,
                         maker_fault_summary,
                         power_good_live,
                         1'b0,
                         other_fault_summary,
                         1'b0,
                         summary_byte};

  // Overvoltage alert: the per-source mask splits, bit 7 mask covers all
  logic                 ovf_alert;
  logic                 lat_alert;
  logic                 output_voltage_summary_alert;

  // A source counts only if neither its own mask nor the shared one is set
  assign ovf_alert  = |(ovp_src_flags & ~alert_mask_ext_reg) &&
                      !alert_mask_output_voltage_summary[VS_OVF_BIT];
  // Warnings and the other voltage faults each have their own mask bit
  assign lat_alert  = |(output_voltage_summary_lat_flags &
                        ~alert_mask_output_voltage_summary[VS_LATCH_HI:VS_LATCH_LO]);
  assign output_voltage_summary_alert = ovf_alert || lat_alert;

  // Summary bits that alert only through the gated voltage path
  logic [15:0]          gated_bits;

  // Built per bit from the field positions, so the gate follows the fields
  for (genvar g = 0; g < 16; g++)
  begin : g_gated
    assign gated_bits[g] = (g == SW_OUTPUT_VOLTAGE_SUMMARY_BIT) || (g == SB_OUTPUT_VOLTAGE_SUMMARY_OV_BIT);
  end

  // Word-level alert vector; voltage bits use the gated voltage path
  logic [15:0]          alert_vec;
  logic                 alert_word;
  logic                 alert_cat;
  logic                 alert_ovf;
  logic                 alert_raw;

  assign alert_vec  = summary_word & ALERT_CAPABLE & ~alert_mask_reg;
  // Plain category and summary bits go straight through their masks
  assign alert_word = |(alert_vec & ~gated_bits);
  // The voltage category alerts only through flags that are not masked,
  // so a masked source cannot hold the alert up through bit 15
  assign alert_cat  = output_voltage_summary_alert && !alert_mask_reg[SW_OUTPUT_VOLTAGE_SUMMARY_BIT];
  // Summary byte bit 5 alerts only for an unmasked overvoltage source
  assign alert_ovf  = ovf_alert && !alert_mask_reg[SB_OUTPUT_VOLTAGE_SUMMARY_OV_BIT];
  assign alert_raw  = alert_word || alert_cat || alert_ovf;

  // Read data selection, upper byte zero for the byte register
  logic [15:0]          rd_sel;
  logic                 rd_any;
  logic                 unknown_clr;

  assign rd_sel      = rd_word ? summary_word :
                       rd_output_voltage_summary ? {8'h00, output_voltage_summary_status} : RD_DATA_RST;
  assign rd_any      = rd_word || rd_output_voltage_summary;
  // Unknown-command flag lives elsewhere; this pulse asks it to clear
  assign unknown_clr = wr_word && cmd_wdata[WR_UNKNOWN_CLR_BIT];

  // Read answer: strobe and data for one cycle, one edge after the command.
  // Data fall back to zero on other cycles so nothing stale is left shown.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      rd_valid_ff <= 1'b0;
      rd_data_ff  <= RD_DATA_RST;
    end
    else
    begin
      rd_valid_ff <= rd_any;
      rd_data_ff  <= rd_sel;
    end
  end

  // Refusal pulse; a refused command touches no flag.
  // Wrong size covers a byte access to 79h and a word access to 7Ah.
  always_ff @(posedge clock)
  begin
    if (srst)
      cmd_reject_ff <= 1'b0;
    else
      cmd_reject_ff <= bad_cmd;
  end

  // Clear request for the unknown-command flag, one cycle wide
  always_ff @(posedge clock)
  begin
    if (srst)
      clear_unknown_cmd_ff <= 1'b0;
    else
      clear_unknown_cmd_ff <= unknown_clr;
  end

  // Word mirror, one clock behind the flags; a read samples the same word
  // at the same edge, so the mirror matches the read answer
  always_ff @(posedge clock)
  begin
    if (srst)
      summary_word_ff <= SUMMARY_WORD_RST;
    else
      summary_word_ff <= summary_word;
  end

  // Voltage status mirror
  always_ff @(posedge clock)
  begin
    if (srst)
      output_voltage_status_ff <= OUTPUT_VOLTAGE_SUMMARY_STATUS_RST;
    else
      output_voltage_status_ff <= output_voltage_summary_status;
  end

  // Alert level; a mask change acts one clock later, like a flag change,
  // since the masks live outside and are not registered again here
  always_ff @(posedge clock)
  begin
    if (srst)
      alert_ff <= 1'b0;
    else
      alert_ff <= alert_raw;
  end

endmodule

// file: test/fault_status_checker.sv
// Port assertions for the fault status bank
`timescale 1ns/1ps
module fault_status_checker
  import fault_status_pkg::*;
(
  input wire logic        clock,
  input wire logic        srst,
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_code,
  input wire logic        cmd_write,
  input wire logic        cmd_is_word,
  input wire logic [15:0] cmd_wdata,
  input wire logic        clear_faults,
  input wire logic        power_good_live,
  input wire logic [15:0] alert_mask_reg,
  input wire logic [7:0]  alert_mask_output_voltage_summary,
  input wire logic [2:0]  alert_mask_ext_reg,
  input wire logic        rd_valid_ff,
  input wire logic        cmd_reject_ff,
  input wire logic        clear_unknown_cmd_ff,
  input wire logic [15:0] summary_word_ff,
  input wire logic [7:0]  output_voltage_status_ff,
  input wire logic        alert_ff
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // Only these code and size pairs are answered
  logic good_cmd;
  assign good_cmd = (cmd_code == CMD_SUMMARY_WORD && cmd_is_word) ||
                    (cmd_code == CMD_OUTPUT_VOLTAGE_SUMMARY_STATUS && !cmd_is_word);
  sequence s_read;
    cmd_valid && !cmd_write && good_cmd;
  endsequence
  sequence s_unknown_clr;
    cmd_valid && cmd_write && good_cmd && cmd_is_word && cmd_wdata[8];
  endsequence
  // Flags land one edge after a request and mirrors one more
  sequence s_clear_req;
    $past(clear_faults, 2) || ($past(cmd_valid, 2) && $past(cmd_write, 2)
      && $past(cmd_code, 2) == CMD_OUTPUT_VOLTAGE_SUMMARY_STATUS && !$past(cmd_is_word, 2));
  endsequence
  a_read_answer: assert property (s_read |=> rd_valid_ff)
    else $error("read got no answer");
  a_bad_reject: assert property (cmd_valid && !good_cmd |=>
    cmd_reject_ff && !rd_valid_ff) else $error("bad command not refused");
  a_unknown_clear: assert property (s_unknown_clr |=> clear_unknown_cmd_ff)
    else $error("unknown clear missing");
  a_unsup_zero: assert property (summary_word_ff[10] == 1'b0 &&
    summary_word_ff[8] == 1'b0 && output_voltage_status_ff[1:0] == 2'b00)
    else $error("unsupported bit set");
  a_power_good_live_live: assert property (1'b1 |=>
    summary_word_ff[SW_POWER_GOOD_LIVE_BIT] == $past(power_good_live))
    else $error("power good not live");
  a_output_voltage_summary_summary: assert property (summary_word_ff[SW_OUTPUT_VOLTAGE_SUMMARY_BIT] ==
    (|output_voltage_status_ff)) else $error("voltage summary wrong");
  a_ovf_summary: assert property (summary_word_ff[SB_OUTPUT_VOLTAGE_SUMMARY_OV_BIT] ==
    output_voltage_status_ff[VS_OVF_BIT]) else $error("ov summary wrong");
  a_flags_hold: assert property (|($past(output_voltage_status_ff) &
    ~output_voltage_status_ff) |-> s_clear_req)
    else $error("flag fell without clear");
  a_alert_masked: assert property ((&alert_mask_reg && &alert_mask_output_voltage_summary
    && &alert_mask_ext_reg)[*2] |-> !alert_ff) else $error("masked alert");
endmodule
bind fault_status_summary_regs fault_status_checker chk_u (
  .clock, .srst, .cmd_valid, .cmd_code, .cmd_write, .cmd_is_word,
  .cmd_wdata, .clear_faults, .power_good_live, .alert_mask_reg,
  .alert_mask_output_voltage_summary, .alert_mask_ext_reg, .rd_valid_ff, .cmd_reject_ff,
  .clear_unknown_cmd_ff, .summary_word_ff, .output_voltage_status_ff,
  .alert_ff
);

// file: test/host_cmd_model.sv
// Host side model: issues commands and collects read answers
`timescale 1ns/1ps
module host_cmd_model
(
  input  wire logic        clock,
  input  wire logic        rd_valid_ff,
  input  wire logic [15:0] rd_data_ff,
  output logic             cmd_valid,
  output logic [7:0]       cmd_code,
  output logic             cmd_write,
  output logic             cmd_is_word,
  output logic [15:0]      cmd_wdata,
  output logic             clear_faults
);
  initial
  begin
    cmd_valid    = 1'b0;
    cmd_code     = 8'h00;
    cmd_write    = 1'b0;
    cmd_is_word  = 1'b0;
    cmd_wdata    = 16'h0000;
    clear_faults = 1'b0;
  end
  // One-cycle strobe; after it the bus shows inverted data, not the old
  task automatic cmd(input logic [7:0] c, input logic w, input logic k,
                     input logic [15:0] d);
    // An edge passes first so the strobe never falls and rises in one step
    @(posedge clock);
    #1;
    cmd_code    = c;
    cmd_write   = w;
    cmd_is_word = k;
    cmd_wdata   = d;
    cmd_valid   = 1'b1;
    @(posedge clock);
    #1;
    cmd_valid   = 1'b0;
    cmd_code    = ~c;
    cmd_wdata   = ~d;
  endtask
  // The answer is registered at the edge that takes the request
  task automatic rd(input logic [7:0] c, input logic k,
                    output logic [15:0] q, output logic ok);
    cmd(c, 1'b0, k, 16'h0000);
    ok = rd_valid_ff;
    q  = rd_data_ff;
  endtask
  task automatic clr();
    clear_faults = 1'b1;
    @(posedge clock);
    #1;
    clear_faults = 1'b0;
  endtask
endmodule

// file: test/test_fault_status_summary_regs.sv
// Self-checking bench for the fault status bank
`timescale 1ns/1ps
module test_fault_status_summary_regs
  import fault_status_pkg::*;
;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic cmd_valid, cmd_write, cmd_is_word, clear_faults;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, rd_data_ff, summary_word_ff;
  logic rd_valid_ff, cmd_reject_ff, clear_unknown_cmd_ff, alert_ff;
  logic [7:0] output_voltage_status_ff;
  logic [8:0] evt = 9'h000;
  logic [10:0] live = 11'h000;
  logic [15:0] alert_mask_reg = 16'h0000;
  logic [7:0] alert_mask_output_voltage_summary = 8'h00;
  logic [2:0] alert_mask_ext_reg = 3'h0;
  int pos[11] = '{6, 4, 3, 2, 1, 0, 14, 13, 12, 11, 9};
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;
  host_cmd_model host_u (.clock, .rd_valid_ff, .rd_data_ff, .cmd_valid,
    .cmd_code, .cmd_write, .cmd_is_word, .cmd_wdata, .clear_faults);
  fault_status_summary_regs dut_u (.clock, .srst, .cmd_valid, .cmd_code,
    .cmd_write, .cmd_is_word, .cmd_wdata, .clear_faults,
    .ovp_fixed_evt(evt[0]), .ovp_tracking_evt(evt[1]),
    .ovp_prebias_evt(evt[2]), .out_overvoltage_warn(evt[3]),
    .out_undervoltage_warn(evt[4]), .out_undervoltage_fault(evt[5]),
    .out_setpoint_limit_hit(evt[6]), .turn_on_timeout(evt[7]),
    .busy_evt(evt[8]), .unit_off_live(live[0]), .output_current_summary_oc_summary(live[1]),
    .vin_uv_summary(live[2]), .temp_summary(live[3]),
    .cml_summary(live[4]), .none_above_summary(live[5]),
    .output_current_summary(live[6]), .input_fault_summary(live[7]),
    .maker_fault_summary(live[8]), .power_good_live(live[9]),
    .other_fault_summary(live[10]), .alert_mask_reg, .alert_mask_output_voltage_summary,
    .alert_mask_ext_reg, .rd_valid_ff, .rd_data_ff, .cmd_reject_ff,
    .clear_unknown_cmd_ff, .summary_word_ff, .output_voltage_status_ff,
    .alert_ff);
  initial
  begin
    forever #5 clock = ~clock;
  end
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      end_sim();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Read a register and compare both the strobe and the data
  task automatic rchk(input logic [7:0] c, input logic [15:0] exp);
    logic [15:0] q;
    logic ok;
    host_u.rd(c, c == CMD_SUMMARY_WORD, q, ok);
    chk({15'h0000, ok}, 16'h0001);
    chk(q, exp);
  endtask
  // Each live summary input must land on its own word bit
  task automatic t_live();
    rchk(CMD_SUMMARY_WORD, 16'h0000);
    rchk(CMD_OUTPUT_VOLTAGE_SUMMARY_STATUS, 16'h0000);
    for (int i = 0; i < 11; i++)
    begin
      live = 11'h001 << i;
      tick(2);
      rchk(CMD_SUMMARY_WORD, 16'h0001 << pos[i]);
    end
    live = 11'h000;
    $display("Live summary test done");
  endtask
  // Every voltage event latches, survives a write of 0003h, clears on one
  task automatic t_output_voltage_summary();
    int b;
    for (int i = 0; i < 8; i++)
    begin
      b = (i < 3) ? 7 : 9 - i;
      evt[i] = 1'b1;
      tick(1);
      evt[i] = 1'b0;
      tick(2);
      rchk(CMD_OUTPUT_VOLTAGE_SUMMARY_STATUS, 16'h0001 << b);
      chk({8'h00, output_voltage_status_ff}, 16'h0001 << b);
      chk(summary_word_ff, (b == 7) ? 16'h8020 : 16'h8000);
      chk({15'h0000, alert_ff}, 16'h0001);
      host_u.cmd(CMD_OUTPUT_VOLTAGE_SUMMARY_STATUS, 1'b1, 1'b0, 16'h0003);
      rchk(CMD_OUTPUT_VOLTAGE_SUMMARY_STATUS, 16'h0001 << b);
      host_u.cmd(CMD_OUTPUT_VOLTAGE_SUMMARY_STATUS, 1'b1, 1'b0, 16'h0001 << b);
      tick(1);
      rchk(CMD_OUTPUT_VOLTAGE_SUMMARY_STATUS, 16'h0000);
      chk(summary_word_ff, 16'h0000);
      chk({8'h00, output_voltage_status_ff}, 16'h0000);
    end
    $display("Voltage status test done");
  endtask
  // Busy clears through bit 7 of a word write, not through the other bits
  task automatic t_busy();
    evt[8] = 1'b1;
    tick(1);
    evt[8] = 1'b0;
    rchk(CMD_SUMMARY_WORD, 16'h0080);
    host_u.cmd(CMD_SUMMARY_WORD, 1'b1, 1'b1, 16'h7F7F);
    rchk(CMD_SUMMARY_WORD, 16'h0080);
    host_u.cmd(CMD_SUMMARY_WORD, 1'b1, 1'b1, 16'h0080);
    chk({15'h0000, clear_unknown_cmd_ff}, 16'h0000);
    rchk(CMD_SUMMARY_WORD, 16'h0000);
    evt[8] = 1'b1;
    tick(1);
    evt[8] = 1'b0;
    host_u.cmd(CMD_SUMMARY_WORD, 1'b1, 1'b1, 16'h0180);
    chk({15'h0000, clear_unknown_cmd_ff}, 16'h0001);
    rchk(CMD_SUMMARY_WORD, 16'h0000);
    $display("Busy test done");
  endtask
  // Wrong code or wrong size is refused
  task automatic t_reject();
    host_u.cmd(8'h7B, 1'b0, 1'b0, 16'h0000);
    chk({cmd_reject_ff, rd_valid_ff}, 16'h0002);
    host_u.cmd(CMD_SUMMARY_WORD, 1'b0, 1'b0, 16'h0000);
    chk({cmd_reject_ff, rd_valid_ff}, 16'h0002);
    host_u.cmd(CMD_OUTPUT_VOLTAGE_SUMMARY_STATUS, 1'b0, 1'b1, 16'h0000);
    chk({cmd_reject_ff, rd_valid_ff}, 16'h0002);
    $display("Reject test done");
  endtask
  // Masks silence the alert; clear-faults wipes every flag
  task automatic t_clear();
    {alert_mask_reg, alert_mask_output_voltage_summary, alert_mask_ext_reg} = 27'h7FF_FFFF;
    evt = 9'h1FF;
    tick(1);
    evt = 9'h000;
    tick(2);
    chk({15'h0000, alert_ff}, 16'h0000);
    rchk(CMD_OUTPUT_VOLTAGE_SUMMARY_STATUS, 16'h00FC);
    host_u.clr();
    rchk(CMD_OUTPUT_VOLTAGE_SUMMARY_STATUS, 16'h0000);
    rchk(CMD_SUMMARY_WORD, 16'h0000);
    {alert_mask_reg, alert_mask_output_voltage_summary, alert_mask_ext_reg} = 27'h000_0001;
    evt[0] = 1'b1;
    tick(1);
    evt[0] = 1'b0;
    tick(2);
    chk({15'h0000, alert_ff}, 16'h0000);
    evt[1] = 1'b1;
    tick(1);
    evt[1] = 1'b0;
    tick(2);
    chk({15'h0000, alert_ff}, 16'h0001);
    host_u.clr();
    $display("Clear and mask test done");
  endtask
  initial
  begin
    repeat (12) @(posedge clock);
    #1;
    srst = 1'b0;
    t_live();
    t_output_voltage_summary();
    t_busy();
    t_reject();
    t_clear();
    end_sim();
  end
endmodule
